// [logic/dpo_bank.sv]
// chain port debug register bank on APB: die id, unlock key, override control, status
// assumes a single 50 MHz clock; port hardware requests arrive synchronous to it
//
// Function
// [RULE_01] die id reads zero after reset, then the factory stored byte; read-only
// [RULE_02] overrides act only with the unlock key written; any other value cancels them
// [RULE_03] control bits 6..3 enable low tx, low rx, high tx, high rx; reset 1
// [RULE_04] manual daisy bit 0 selects control bits over hardware for port enables
// [RULE_05] baud force bit switches host uart to the fixed 250 kb/s rate
// [RULE_06] user uart bit 1 gates the baud force bit
// [RULE_07] status bit 4 reads 0 under manual override, 1 under hardware control
// [RULE_08] status bits 3..0 show live port enables; reset 0,0,1,1
// [RULE_09] writes to read-only registers are ignored; reserved bits read zero
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"
module dpo_bank
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // factory store
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_data,
  // hardware port requests, msb low tx .. lsb high rx
  input wire logic [3:0] hw_port_enable,
  // normal host uart divisor
  input wire logic [15:0] host_baud_div,
  // port enables to the chain front ends
  output logic low_side_transmit_enable,
  output logic low_side_receive_enable,
  output logic high_side_transmit_enable,
  output logic high_side_receive_enable,
  // host uart rate
  output logic host_baud_force,
  output logic host_bit_tick
);
  typedef struct packed {
    logic [7:0] key;
    logic [7:0] ctrl;
    dpo_ports_t ports;
    logic force_baud;
    logic [31:0] rdata;
  } dpo_bank_state_t;
  dpo_bank_state_t state, next_state;

  logic [7:0] id_byte;
  logic unlocked;
  logic manual;
  logic [7:0] stat_byte;
  logic access;
  logic [`DPO_ADDR_W-1:0] addr;
  logic hit;
  dpo_rate_t rate_sel;

  // die id capture from the factory store
  dpo_id_loader u_id (
    .pclk(pclk),
    .presetn(presetn),
    .nvm_valid(nvm_valid),
    .nvm_data(nvm_data),
    .id_byte(id_byte)
  );

  // host bit-rate enable follows the effective force setting
  assign rate_sel = state.force_baud ? DPO_RATE_FORCED : DPO_RATE_NORMAL;
  dpo_rate_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .rate_sel(rate_sel),
    .normal_div(host_baud_div),
    .bit_tick(host_bit_tick)
  );

  // effective override state
  assign unlocked = (state.key == `DPO_UNLOCK_CODE); // [RULE_02]
  assign manual = unlocked && state.ctrl[`DPO_CTRL_DAISY]; // [RULE_04]
  // status shows the enables actually driven, not the requested bits
  assign stat_byte = {3'b000, !manual, state.ports}; // [RULE_07] [RULE_08]

  // apb decode; upper address bits must be zero to hit
  assign access = psel && penable;
  assign addr = paddr[`DPO_ADDR_W-1:0];
  assign hit = (paddr[31:`DPO_ADDR_W] == '0) && (paddr[1:0] == 2'b00) &&
               (addr == `DPO_ADDR_DIE_ID || addr == `DPO_ADDR_UNLOCK ||
                addr == `DPO_ADDR_CTRL || addr == `DPO_ADDR_STAT);

  // register file and live port selection
  always_comb begin
    next_state = state;
    if (access && pwrite && hit && pstrb[0]) begin
      // die id and status are read-only, writes there fall through
      if (addr == `DPO_ADDR_UNLOCK) begin // [RULE_09]
        next_state.key = pwdata[7:0]; // [RULE_02]
      end else if (addr == `DPO_ADDR_CTRL) begin
        next_state.ctrl = pwdata[7:0] & `DPO_CTRL_MASK; // [RULE_03] [RULE_09]
      end
    end
    // read data captured in the setup cycle, so it already stands at the access edge
    // where the master takes it; unmapped reads give zero
    if (psel && !penable && !pwrite) begin
      next_state.rdata = 32'h00000000;
      if (addr == `DPO_ADDR_DIE_ID) begin
        next_state.rdata = {`DPO_BYTE_ZERO, id_byte}; // [RULE_01]
      end else if (addr == `DPO_ADDR_UNLOCK) begin
        next_state.rdata = {`DPO_BYTE_ZERO, state.key};
      end else if (addr == `DPO_ADDR_CTRL) begin
        next_state.rdata = {`DPO_BYTE_ZERO, state.ctrl};
      end else if (addr == `DPO_ADDR_STAT) begin
        next_state.rdata = {`DPO_BYTE_ZERO, stat_byte}; // [RULE_09]
      end
      if (!hit) begin
        next_state.rdata = 32'h00000000;
      end
    end
    // manual mode takes the control bits, else the hardware requests
    if (manual) begin
      next_state.ports = state.ctrl[`DPO_CTRL_PORT_MSB:`DPO_CTRL_PORT_LSB]; // [RULE_04]
    end else begin
      next_state.ports = hw_port_enable; // [RULE_04]
    end
    // baud force only when unlocked and gated by the user uart bit
    next_state.force_baud = unlocked && state.ctrl[`DPO_CTRL_UART] &&
                            state.ctrl[`DPO_CTRL_BAUD]; // [RULE_05] [RULE_06]
  end

  // state register; port reset matches the status reset pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{key: `DPO_UNLOCK_RESET, ctrl: `DPO_CTRL_RESET,
                 ports: `DPO_PORTS_HW_RESET, force_baud: 1'b0,
                 rdata: 32'h00000000}; // [RULE_03] [RULE_08]
    end else begin
      state <= next_state;
    end
  end

  // zero wait state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = state.rdata;

  // port outputs come straight from flops
  assign low_side_transmit_enable = state.ports[3];
  assign low_side_receive_enable = state.ports[2];
  assign high_side_transmit_enable = state.ports[1];
  assign high_side_receive_enable = state.ports[0];
  assign host_baud_force = state.force_baud;
endmodule
`default_nettype wire

// [logic/dpo_map.svh]
// register map, field positions, reset values and timing for the chain port debug bank
// assumes byte-wide registers held in the low bits of a 32-bit APB word
`ifndef DPO_MAP_SVH
`define DPO_MAP_SVH
// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define DPO_IDX_DIE_ID 16'h2129
`define DPO_IDX_UNLOCK 16'h2200
`define DPO_IDX_CTRL 16'h2201
`define DPO_IDX_STAT 16'h2300
`define DPO_ADDR_W 18
`define DPO_ADDR_DIE_ID 18'h084A4
`define DPO_ADDR_UNLOCK 18'h08800
`define DPO_ADDR_CTRL 18'h08804
`define DPO_ADDR_STAT 18'h08C00
// unlock key value, arbitrary
`define DPO_UNLOCK_CODE 8'hA5
// control fields
`define DPO_CTRL_DAISY 0
`define DPO_CTRL_UART 1
`define DPO_CTRL_BAUD 2
`define DPO_CTRL_PORT_LSB 3
`define DPO_CTRL_PORT_MSB 6
`define DPO_CTRL_RESET 8'h78
`define DPO_CTRL_MASK 8'h7F
// status fields
`define DPO_STAT_HW_BIT 4
`define DPO_PORTS_HW_RESET 4'h3
`define DPO_ID_RESET 8'h00
`define DPO_UNLOCK_RESET 8'h00
`define DPO_BYTE_ZERO 24'h000000
// fixed forced host rate and its bit period in cycles at 50 MHz
`define DPO_CLK_HZ 50000000
`define DPO_FORCED_BAUD 250000
`define DPO_FORCED_DIV (`DPO_CLK_HZ / `DPO_FORCED_BAUD)
`endif

// [logic/dpo_pkg.sv]
// types shared by the chain port debug bank
// assumes dpo_map.svh for all numbers
package dpo_pkg;
  // order of port enables: low tx, low rx, high tx, high rx (msb first)
  typedef logic [3:0] dpo_ports_t;
  typedef enum logic [1:0] {
    DPO_RATE_NORMAL = 2'b01,
    DPO_RATE_FORCED = 2'b10
  } dpo_rate_t;
endpackage

// [logic/dpo_id_loader.sv]
// captures the die identity byte once the factory store reports a good load
// assumes nvm_valid is a level that rises after reset and nvm_data is stable with it
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"
module dpo_id_loader
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // factory store
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_data,
  // captured byte
  output logic [7:0] id_byte
);
  typedef struct packed {
    logic [7:0] id;
    logic loaded;
  } dpo_idl_state_t;
  dpo_idl_state_t state, next_state;

  // take the byte only once, a later glitch on the store cannot change it
  always_comb begin
    next_state = state;
    if (nvm_valid && !state.loaded) begin
      next_state.id = nvm_data; // [RULE_01]
      next_state.loaded = 1'b1;
    end
  end

  // zero until the load succeeds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{id: `DPO_ID_RESET, loaded: 1'b0}; // [RULE_01]
    end else begin
      state <= next_state;
    end
  end

  assign id_byte = state.id;
endmodule
`default_nettype wire

// [logic/dpo_rate_tick.sv]
// bit-rate enable for the host uart: normal divider or the fixed forced rate
// assumes the normal divisor is static while enabled
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"
module dpo_rate_tick
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // rate selection
  input wire dpo_rate_t rate_sel,
  input wire logic [15:0] normal_div,
  // one-cycle bit enable
  output logic bit_tick
);
  localparam logic [15:0] FORCED_DIV = 16'(`DPO_FORCED_DIV);
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } dpo_tick_state_t;
  dpo_tick_state_t state, next_state;
  logic [15:0] div;

  // a zero normal divisor is clamped to one so the tick never stalls
  always_comb begin
    div = (rate_sel == DPO_RATE_FORCED) ? FORCED_DIV : normal_div; // [RULE_05]
    if (div == 16'h0000) begin
      div = 16'h0001;
    end
    next_state.tick = 1'b0;
    next_state.count = state.count + 16'h0001;
    if (state.count + 16'h0001 >= div) begin
      next_state.count = 16'h0000;
      next_state.tick = 1'b1;
    end
  end

  // counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{count: 16'h0000, tick: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign bit_tick = state.tick;
endmodule
`default_nettype wire

// [tb/dpo_chk_asserts.sv]
// checker for dpo_bank: decode, read-back, port outputs and the baud force output
// assumes it is bound into dpo_bank and sees only its ports
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"
module dpo_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // store, requests and outputs
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_data,
  input wire logic [3:0] hw_port_enable,
  input wire logic low_side_transmit_enable,
  input wire logic low_side_receive_enable,
  input wire logic high_side_transmit_enable,
  input wire logic high_side_receive_enable,
  input wire logic host_baud_force
);
  logic [7:0] key, ctl, idv;
  logic got;
  wire logic [3:0] ports = {low_side_transmit_enable, low_side_receive_enable,
    high_side_transmit_enable, high_side_receive_enable};
  wire logic wr = psel && penable && pwrite && pstrb[0];
  wire logic man = key == `DPO_UNLOCK_CODE && ctl[0];
  wire logic frc = key == `DPO_UNLOCK_CODE && ctl[1] && ctl[2];
  wire logic map = paddr inside {`DPO_ADDR_DIE_ID, `DPO_ADDR_UNLOCK, `DPO_ADDR_CTRL,
    `DPO_ADDR_STAT};
  // shadows of the written bytes; id kept from the first good load only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key <= `DPO_UNLOCK_RESET;
      ctl <= `DPO_CTRL_RESET;
      idv <= `DPO_ID_RESET;
      got <= 1'b0;
    end else begin
      if (wr && paddr == `DPO_ADDR_UNLOCK) key <= pwdata[7:0];
      if (wr && paddr == `DPO_ADDR_CTRL) ctl <= pwdata[7:0] & `DPO_CTRL_MASK;
      if (nvm_valid && !got) idv <= nvm_data;
      got <= got || nvm_valid;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(a); psel && penable && !pwrite && paddr == a; endsequence
  property p_err; psel && penable |-> pslverr == !map; endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_unm; psel && penable && !pwrite && !map |-> prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_ports; $past(presetn) |-> ports == $past(man ? ctl[6:3] : hw_port_enable); endproperty
  a_ports: assert property (p_ports) else $error("port enables wrong");
  property p_force; $past(presetn) |-> host_baud_force == $past(frc); endproperty
  a_force: assert property (p_force) else $error("rate force wrong");
  // read data must stand at the access edge, holding the value of the setup edge
  property p_ctl; s_rd(`DPO_ADDR_CTRL) |-> prdata == {24'h0, $past(ctl)}; endproperty
  a_ctl: assert property (p_ctl) else $error("control read wrong");
  property p_key; s_rd(`DPO_ADDR_UNLOCK) |-> prdata == {24'h0, $past(key)}; endproperty
  a_key: assert property (p_key) else $error("key read wrong");
  property p_stat;
    s_rd(`DPO_ADDR_STAT) |-> prdata == {27'h0, !$past(man), $past(ports)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_id; s_rd(`DPO_ADDR_DIE_ID) |-> prdata == {24'h0, $past(idv)}; endproperty
  a_id: assert property (p_id) else $error("id read wrong");
endmodule
bind dpo_bank dpo_chk i_dpo_chk (.*);
`default_nettype wire

// [tb/dpo_far.sv]
// factory store model: good load 40 cycles after reset
// assumes the bench supplies the stored byte
`timescale 1ns/10ps
`default_nettype none
module dpo_far (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stored byte and load report
  input wire logic [7:0] id_byte,
  output logic nvm_valid,
  output logic [7:0] nvm_data
);
  logic [5:0] cnt;
  // load time; data is junk until the load is good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 6'h00;
    else if (!nvm_valid) cnt <= cnt + 6'h01;
  end
  assign nvm_valid = cnt == 6'h28;
  assign nvm_data = nvm_valid ? id_byte : ~id_byte;
endmodule
`default_nettype wire

// [tb/tb.sv]
// bench for dpo_bank: apb master, random traffic, read-back checks
// assumes dpo_far as factory store and dpo_chk bound to the bank
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_valid, host_bit_tick;
  logic low_side_transmit_enable, low_side_receive_enable, host_baud_force;
  logic high_side_transmit_enable, high_side_receive_enable;
  logic [31:0] paddr, pwdata, prdata, rd, r, seed;
  logic [15:0] host_baud_div;
  logic [7:0] nvm_data, id_byte, key, ctl;
  logic [3:0] pstrb, hw_port_enable;
  int errors = 0, compares = 0, n;
  dpo_far i_dpo_far (.*);
  dpo_bank i_dpo_bank (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status expected from the shadows and the hardware requests
  function automatic logic [31:0] stat_exp();
    logic m;
    m = key == `DPO_UNLOCK_CODE && ctl[0];
    return {27'h0, !m, m ? ctl[6:3] : hw_port_enable};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer; read data taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= {3'h7, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && s && a == `DPO_ADDR_UNLOCK) key = d;
    if (w && s && a == `DPO_ADDR_CTRL) ctl = d & `DPO_CTRL_MASK;
    // idle edge, so a following call never re-raises psel in this time step
    @(posedge pclk);
  endtask
  // edges between two bit ticks; the first two ticks let the new rate settle
  task automatic tick_gap(output int g);
    repeat (2) @(posedge pclk iff host_bit_tick);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (host_bit_tick !== 1'b1);
  endtask
  task automatic final_report();
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard, about fourteen times the expected run
  initial begin
    #400000;
    errors++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    seed = 32'h51B19F36;
    key = `DPO_UNLOCK_RESET;
    ctl = `DPO_CTRL_RESET;
    hw_port_enable = 4'hC;
    host_baud_div = 16'h0010;
    r = rnd();
    id_byte = r[7:0];
    repeat (4) @(posedge pclk);
    chk("ports", 32'h3, {28'h0, low_side_transmit_enable, low_side_receive_enable,
      high_side_transmit_enable, high_side_receive_enable});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DPO_ADDR_DIE_ID, 8'h00, 1'b1);
    chk("id", 32'h0, rd);
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      if (i > 0) hw_port_enable <= r[3:0];
      if (r[5:4] == 2'h0) apb(1'b1, `DPO_ADDR_UNLOCK, r[6] ? `DPO_UNLOCK_CODE : r[15:8], 1'b1);
      else if (r[5:4] == 2'h1 && i > 0) apb(1'b1, `DPO_ADDR_CTRL, r[15:8], r[16]);
      else apb(1'b1, r[6] ? `DPO_ADDR_STAT : `DPO_ADDR_DIE_ID, r[15:8], 1'b1);
      apb(1'b0, `DPO_ADDR_STAT, 8'h00, 1'b1);
      chk("stat", stat_exp(), rd);
      apb(1'b0, `DPO_ADDR_CTRL, 8'h00, 1'b1);
      chk("ctrl", {24'h0, ctl}, rd);
      chk("force", {31'h0, key == `DPO_UNLOCK_CODE && ctl[2:1] == 2'h3},
        {31'h0, host_baud_force});
    end
    apb(1'b0, `DPO_ADDR_UNLOCK, 8'h00, 1'b1);
    chk("key", {24'h0, key}, rd);
    apb(1'b0, `DPO_ADDR_DIE_ID, 8'h00, 1'b1);
    chk("id", {24'h0, id_byte}, rd);
    apb(1'b0, 32'h00000101, 8'h00, 1'b1);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, `DPO_ADDR_UNLOCK, `DPO_UNLOCK_CODE, 1'b1);
    // baud force without the user uart bit keeps the normal divisor
    apb(1'b1, `DPO_ADDR_CTRL, 8'h04, 1'b1);
    tick_gap(n);
    chk("tick", 32'(host_baud_div), 32'(n));
    apb(1'b1, `DPO_ADDR_CTRL, 8'h06, 1'b1);
    tick_gap(n);
    chk("tick", `DPO_FORCED_DIV, 32'(n));
    final_report();
  end
endmodule
`default_nettype wire
